// >>> logic/selftest_sample_seq.sv
// Module: self-test sequencer, init phase 3 status and sample latch timing
`timescale 1ns/1ps
//
// Contract
// - Self-test runs phases one, two, three in order during init phases two and three.
// - Phase one keeps stimulus off and averages offset into raw offset.
// - With extended init flag, expose 10-bit raw offset and self-test results.
// - Offset cancellation frozen for phase-two time plus 2 ms.
// - Stimulus on, wait half phase two, average remaining half for self-test value.
// - Compare average to pass limits, then stimulus off before phase three.
// - Phase three averages offset again to set normal baseline.
// - Failed check reruns phases one to three up to retry limit; pass goes normal.
// - Sequence ends at first passing pass, no further retries.
// - Init phase three sends busy frames, then exactly two ready or defect frames; defect frames here keep repeating.
// - Phase-three time is ceil(remaining self-check time / sync period) plus 2 periods.
// - Free-run mode when mode field 00, free-run bit 1, slot-A offset zero.
// - Free-run mode sends frames at fixed period and ignores sync pulses.
// - In init phase one free-run still decodes programming entry, only if unlocked.
// - Simultaneous sampling latches newest sample at sync rise, sends at slot A.
// - Minimum-latency sampling latches and sends at slot-A offset after sync rise.
// - Send zeros for results when sync period too short for phases one, two.
module selftest_sample_seq
  import selftest_timing_pkg::*;
#(
  parameter int PH1_CYCLES   = 20000,   // phase1_average_time in clock cycles
  parameter int PH2_CYCLES   = 20000,   // phase2_selftest_time in clock cycles
  parameter int PH3_CYCLES   = 20000,   // phase3_average_time in clock cycles
  parameter int FREEZE_EXTRA = selftest_timing_pkg::OC_FREEZE_CYCLES,
  parameter int FREE_RUN_CYC = 45600,   // free_run_period in clock cycles
  parameter int LIM_LO       = 100,
  parameter int LIM_HI       = 400
) (
  input  wire logic                                clk,
  input  wire logic                                reset_n,
  input  wire logic                                clkEn,
  input  wire logic                                initPhase1,
  input  wire logic                                initPhase23,
  input  wire logic                                extendedInitFlag,
  input  wire logic [3:0]                          selftestRetryLimit,
  input  wire selftest_timing_pkg::mode_cfg_type   modeCfg,
  input  wire logic                                userLock,
  input  wire logic                                progEntryDecoded,
  input  wire logic                                syncPulse,
  input  wire logic                                syncPeriodOk,
  input  wire logic                                frameSlot,
  input  wire logic [9:0]                          sensorSample,
  input  wire logic                                txReady,
  output logic                                     selftestStimulus,
  output logic                                     offsetFrozen,
  output logic                                     programmingMode,
  output selftest_timing_pkg::init_result_type     initResult,
  output logic [9:0]                               baseline,
  output selftest_timing_pkg::status_type          statusFrame,
  output logic                                     statusValid,
  output logic                                     normalMode,
  output logic                                     freeRunMode,
  output logic                                     txStart,
  output logic [9:0]                               txData,
  output logic [3:0]                               selftestRetryCountTerm,
  output logic                                     fifoFull
);
  import selftest_timing_pkg::*;

  // ------------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------------
  logic rstMeta_ff;
  logic rstN;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_ff <= 1'b0;
      rstN       <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstN       <= rstMeta_ff;
    end
  end

  // ------------------------------------------------------------------
  // Self-test sequencer
  // ------------------------------------------------------------------
  seq_state_type state_ff;
  logic [31:0]   tmr_ff;
  logic [31:0]   freeze_ff;
  logic [31:0]   accum_ff;
  logic [3:0]    retry_ff;
  logic [9:0]    stValue;
  logic          stPass;
  logic [31:0]   halfPh2;

  assign halfPh2 = 32'(PH2_CYCLES / 2);
  // Averages use the window length; divide by a constant keeps it combinational
  assign stValue = 10'(accum_ff / 32'(PH2_CYCLES - PH2_CYCLES / 2));
  assign stPass  = (int'(stValue) >= LIM_LO) && (int'(stValue) <= LIM_HI);

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state_ff         <= ST_IDLE;
      tmr_ff           <= '0;
      accum_ff         <= '0;
      retry_ff         <= RETRY_RESET;
      selftestStimulus <= 1'b0;
      initResult       <= '0;
    end else if (clkEn) begin
      tmr_ff <= tmr_ff + 32'd1;
      case (state_ff)
        ST_IDLE: begin
          if (initPhase23) begin
            state_ff <= ST_PH1;
            tmr_ff   <= '0;
            accum_ff <= '0;
          end
        end
        ST_PH1: begin
          selftestStimulus <= 1'b0;
          accum_ff         <= accum_ff + 32'(sensorSample);
          if (tmr_ff == 32'(PH1_CYCLES - 1)) begin
            // Hidden results go out as zeros; the pass decision does not use them
            initResult.rawOffset <= showResults
                ? 10'((accum_ff + 32'(sensorSample)) / 32'(PH1_CYCLES))
                : RESULT_ZERO;
            state_ff         <= ST_PH2W;
            tmr_ff           <= '0;
            accum_ff         <= '0;
            selftestStimulus <= 1'b1;
          end
        end
        ST_PH2W: begin
          if (tmr_ff == halfPh2 - 32'd1) begin
            state_ff <= ST_PH2A;
          end
        end
        ST_PH2A: begin
          accum_ff <= accum_ff + 32'(sensorSample);
          if (tmr_ff == 32'(PH2_CYCLES - 1)) begin
            state_ff <= ST_FAIL;                              // check next cycle
          end
        end
        ST_FAIL: begin
          initResult.avgSelfTest <= showResults ? stValue : RESULT_ZERO;
          selftestStimulus       <= 1'b0;
          state_ff               <= ST_PH3;
          tmr_ff                 <= '0;
          accum_ff               <= {31'd0, stPass};          // pass bit parked in bit 0
        end
        ST_PH3: begin
          if (tmr_ff == 32'(PH3_CYCLES - 1)) begin
            tmr_ff <= '0;
            if (accum_ff[0]) begin                            // parked pass bit
              state_ff <= ST_DONE;
            end else if (retry_ff < selftestRetryLimit) begin
              retry_ff <= retry_ff + 4'd1;
              state_ff <= ST_PH1;
              accum_ff <= '0;
            end else begin
              retry_ff <= retry_ff + 4'd1;                    // exceeds limit: defect
              state_ff <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          tmr_ff <= tmr_ff;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Baseline accumulator for phase three runs beside the sequencer
  logic [31:0] base_ff;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      base_ff  <= '0;
      baseline <= RESULT_ZERO;
    end else if (clkEn) begin
      if (state_ff != ST_PH3) begin
        base_ff <= '0;
      end else if (tmr_ff == 32'(PH3_CYCLES - 1)) begin
        baseline <= 10'((base_ff + 32'(sensorSample)) / 32'(PH3_CYCLES));
      end else begin
        base_ff <= base_ff + 32'(sensorSample);
      end
    end
  end

  // Offset cancellation freeze: phase-two time plus the extra 2 ms
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      freeze_ff    <= '0;
      offsetFrozen <= 1'b0;
    end else if (clkEn) begin
      if (state_ff == ST_PH1 && tmr_ff == 32'(PH1_CYCLES - 1)) begin
        freeze_ff    <= 32'(PH2_CYCLES + FREEZE_EXTRA - 1);
        offsetFrozen <= 1'b1;
      end else if (freeze_ff != '0) begin
        freeze_ff <= freeze_ff - 32'd1;
      end else begin
        offsetFrozen <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Init phase three status frames
  // ------------------------------------------------------------------
  logic [1:0] finalCnt_ff;
  logic       defect;
  assign defect = (retry_ff > selftestRetryLimit);
  // Duration follows from the sync cadence: busy frames until done, then two
  // more periods; this gives the rounded-up count of periods plus 2.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      statusFrame <= FR_BUSY;
      statusValid <= 1'b0;
      finalCnt_ff <= '0;
      normalMode  <= 1'b0;
    end else if (clkEn) begin
      statusValid <= 1'b0;
      if (initPhase23 && frameSlot && !normalMode) begin
        statusValid <= 1'b1;
        if (state_ff != ST_DONE) begin
          statusFrame <= FR_BUSY;
        end else begin
          statusFrame <= defect ? FR_DEFECT : FR_READY;
          finalCnt_ff <= finalCnt_ff + 2'd1;
          if (finalCnt_ff == 2'(READY_FRAMES - 1)) begin
            normalMode <= !defect;
          end
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Init phase two results: zero unless enabled and ready in time
  // ------------------------------------------------------------------
  logic showResults;
  assign showResults = extendedInitFlag && syncPeriodOk;

  // ------------------------------------------------------------------
  // Mode decode and programming entry
  // ------------------------------------------------------------------
  logic freeRun;
  assign freeRun = (modeCfg.transmitModeSelect == TX_MODE_NORMAL) && modeCfg.freeRunSelect
                   && (modeCfg.slotAOffset == SLOT_A_ZERO);
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      freeRunMode     <= 1'b0;
      programmingMode <= 1'b0;
    end else if (clkEn) begin
      freeRunMode <= freeRun;
      if (initPhase1 && progEntryDecoded && !userLock) begin
        programmingMode <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Sample latch and slot timing
  // ------------------------------------------------------------------
  logic [31:0] slotTmr_ff;
  logic [31:0] frTmr_ff;
  logic        slotRun_ff;
  logic [9:0]  held_ff;
  logic        push;
  logic        pushReady;
  logic [31:0] slotCycles;
  logic        syncPrev_ff;
  logic        syncRise;
  assign slotCycles = 32'(modeCfg.slotAOffset) * 32'(SLOT_TICK_CYCLES);
  assign syncRise   = syncPulse && !syncPrev_ff;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      syncPrev_ff <= 1'b0;
      slotTmr_ff  <= '0;
      frTmr_ff    <= '0;
      slotRun_ff  <= 1'b0;
      held_ff     <= '0;
      push        <= 1'b0;
    end else if (clkEn) begin
      syncPrev_ff <= syncPulse;
      push        <= 1'b0;
      if (!normalMode) begin
        slotRun_ff <= 1'b0;
      end else if (freeRun) begin
        frTmr_ff <= (frTmr_ff == 32'(FREE_RUN_CYC - 1)) ? '0 : frTmr_ff + 32'd1;
        if (frTmr_ff == '0) begin
          held_ff <= sensorSample;
          push    <= 1'b1;
        end
      end else if (syncRise) begin
        slotRun_ff <= 1'b1;
        slotTmr_ff <= '0;
        if (!modeCfg.latencySync) begin
          held_ff <= sensorSample;
        end
      end else if (slotRun_ff) begin
        slotTmr_ff <= slotTmr_ff + 32'd1;
        if (slotTmr_ff + 32'd1 >= slotCycles) begin
          slotRun_ff <= 1'b0;
          push       <= 1'b1;
          if (modeCfg.latencySync) begin
            held_ff <= sensorSample;
          end
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Output FIFO toward the frame encoder
  // ------------------------------------------------------------------
  logic       fOutValid;
  logic [9:0] fOutData;
  sample_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) uFifo (
    .clk      (clk),
    .rstN     (rstN),
    .clkEn    (clkEn),
    .inValid  (push),
    .inReady  (pushReady),
    .inData   (held_ff),
    .outValid (fOutValid),
    .outReady (txReady && !txStart),
    .outData  (fOutData)
  );

  // Registered outputs; a full FIFO drops the sample and is flagged
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      txStart                <= 1'b0;
      txData                 <= '0;
      fifoFull               <= 1'b0;
      selftestRetryCountTerm <= RETRY_RESET;
    end else if (clkEn) begin
      txStart                <= fOutValid && txReady && !txStart;
      txData                 <= fOutData;
      fifoFull               <= !pushReady;
      selftestRetryCountTerm <= retry_ff;
    end
  end

  // Offset as shown, zero otherwise; feeds only the zero-results assertion
  logic [9:0] shownOffset;
  assign shownOffset = showResults ? initResult.rawOffset : RESULT_ZERO;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  a_stim_off_ph3: assert property (@(posedge clk) disable iff (!rstN)
    (state_ff == ST_PH3) |-> !selftestStimulus)
    else $error("stimulus on in phase three");
  a_stim_off_ph1: assert property (@(posedge clk) disable iff (!rstN)
    (state_ff == ST_PH1) && $past(state_ff == ST_PH1) |-> !selftestStimulus)
    else $error("stimulus on in phase one");
  a_freeze_ph2: assert property (@(posedge clk) disable iff (!rstN)
    (state_ff == ST_PH2A) |-> offsetFrozen)
    else $error("offset not frozen in phase two");
  a_zero_results: assert property (@(posedge clk) disable iff (!rstN)
    !showResults |-> shownOffset == RESULT_ZERO)
    else $error("results shown while hidden");
  a_prog_lock: assert property (@(posedge clk) disable iff (!rstN)
    clkEn && userLock && !programmingMode |=> !programmingMode)
    else $error("programming entered while locked");
  a_no_sync_free: assert property (@(posedge clk) disable iff (!rstN)
    clkEn && freeRun && freeRunMode |=> !slotRun_ff)
    else $error("free-run answered a sync pulse");
  a_done_stays: assert property (@(posedge clk) disable iff (!rstN)
    clkEn && state_ff == ST_DONE |=> state_ff == ST_DONE)
    else $error("sequence left done state");
  a_ph2_order: assert property (@(posedge clk) disable iff (!rstN)
    clkEn && state_ff == ST_PH2W |=> state_ff inside {ST_PH2W, ST_PH2A})
    else $error("phase order broken");

endmodule : selftest_sample_seq

// >>> logic/selftest_timing_pkg.sv
// Package: constants, states and carrier types for the self-test and sample sequencer
package selftest_timing_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS    = 5;
  localparam int          OC_FREEZE_MS     = 2;
  localparam int          OC_FREEZE_CYCLES = OC_FREEZE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int          SLOT_TICK_NS     = 500;          // Slot offset resolution
  localparam int          SLOT_TICK_CYCLES = SLOT_TICK_NS / CLK_PERIOD_NS;
  localparam int          READY_FRAMES     = 2;
  localparam int          EXTRA_PERIODS    = 2;

  // ----------------------------------------------------------------
  // Field values, reset values and FIFO sizes
  // ----------------------------------------------------------------
  localparam logic [1:0]  TX_MODE_NORMAL   = 2'h0;
  localparam logic [9:0]  SLOT_A_ZERO      = 10'h000;
  localparam logic [9:0]  RESULT_ZERO      = 10'h000;
  localparam logic [3:0]  RETRY_RESET      = 4'h0;
  localparam int          DATA_W           = 10;
  localparam int          FIFO_DEPTH       = 8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_PH1   = 7'h02,
    ST_PH2W  = 7'h04,
    ST_PH2A  = 7'h08,
    ST_PH3   = 7'h10,
    ST_DONE  = 7'h20,
    ST_FAIL  = 7'h40
  } seq_state_type;

  typedef enum logic [2:0] {
    FR_BUSY   = 3'h1,
    FR_READY  = 3'h2,
    FR_DEFECT = 3'h4
  } status_type;

  typedef struct packed {
    logic [9:0] rawOffset;
    logic [9:0] avgSelfTest;
  } init_result_type;

  typedef struct packed {
    logic [1:0] transmitModeSelect;
    logic       freeRunSelect;
    logic       latencySync;       // 1: minimum-latency, 0: simultaneous
    logic [9:0] slotAOffset;
  } mode_cfg_type;

endpackage : selftest_timing_pkg

// >>> logic/sample_fifo.sv
// Module: small flip-flop FIFO for latched samples
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rstN,
  input  wire logic             clkEn,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wrPtr_ff;
  logic [AW-1:0]    rdPtr_ff;
  logic [AW:0]      count_ff;
  logic             doWr;
  logic             doRd;

  // Honest flags from the occupancy count
  assign inReady  = (count_ff != (AW+1)'(DEPTH));
  assign outValid = (count_ff != '0);
  assign outData  = mem_ff[rdPtr_ff];
  assign doWr     = clkEn && inValid && inReady;
  assign doRd     = clkEn && outValid && outReady;

  // Storage has no reset; only written words are ever read
  always_ff @(posedge clk) begin
    if (doWr) begin
      mem_ff[wrPtr_ff] <= inData;
    end
  end

  // Pointers and count
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (doWr) begin
        wrPtr_ff <= (wrPtr_ff == AW'(DEPTH-1)) ? '0 : wrPtr_ff + 1'b1;
      end
      if (doRd) begin
        rdPtr_ff <= (rdPtr_ff == AW'(DEPTH-1)) ? '0 : rdPtr_ff + 1'b1;
      end
      if (doWr && !doRd) begin
        count_ff <= count_ff + 1'b1;
      end else if (doRd && !doWr) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

endmodule : sample_fifo

// >>> verification/sync_source.sv
// Partner model: control unit receiver issuing periodic sync pulses
`timescale 1ns/1ps
module sync_source #(
  parameter int PERIOD = 400,
  parameter int WIDTH  = 4
) (
  input  wire logic clk,
  input  wire logic enable,
  output logic      syncPulse
);
  int count = 0;

  // Pulses change off the falling edge, so the device sees clean rises
  always @(negedge clk) begin
    if (!enable) begin
      count     <= 0;
      syncPulse <= 1'b0;
    end else begin
      count     <= (count + 1) % PERIOD;
      syncPulse <= (count < WIDTH);
    end
  end
endmodule : sync_source

// >>> verification/testbench.sv
// Testbench: self-test sequencing, status frames, sample timing and FIFO
`timescale 1ns/1ps
module testbench;
  import selftest_timing_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, clkEn = 1'b1, initPhase1 = 1'b0, initPhase23 = 1'b0;
  logic extendedInitFlag = 1'b1, userLock = 1'b1, progEntryDecoded = 1'b0, syncOn = 1'b0;
  logic syncPeriodOk = 1'b1, frameSlot = 1'b0, txReady = 1'b1, syncPulse;
  logic [3:0] selftestRetryLimit = 4'h0;
  logic [9:0] sensorSample = 10'h000;
  mode_cfg_type modeCfg = '0;
  logic selftestStimulus, offsetFrozen, programmingMode, statusValid, normalMode;
  logic freeRunMode, txStart, fifoFull;
  logic [9:0] baseline, txData;
  logic [3:0] selftestRetryCountTerm;
  init_result_type initResult;
  status_type statusFrame;
  int mismatches = 0, checked = 0, cycles = 0;
  logic [7:0] rnd = 8'h4A;

  selftest_sample_seq #(.PH1_CYCLES(20), .PH2_CYCLES(20), .PH3_CYCLES(20),
    .FREEZE_EXTRA(20), .FREE_RUN_CYC(40)) DUT (.clk, .reset_n, .clkEn, .initPhase1,
    .initPhase23, .extendedInitFlag, .selftestRetryLimit, .modeCfg, .userLock,
    .progEntryDecoded, .syncPulse, .syncPeriodOk, .frameSlot, .sensorSample, .txReady,
    .selftestStimulus, .offsetFrozen, .programmingMode, .initResult, .baseline,
    .statusFrame, .statusValid, .normalMode, .freeRunMode, .txStart, .txData,
    .selftestRetryCountTerm, .fifoFull);
  sync_source partner (.clk(clk), .enable(syncOn), .syncPulse(syncPulse));

  // ------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // ------------------------------------------------------------
  always #2.5 clk = ~clk;
  // A hung handshake must still reach the verdict
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches++;
      test_done();
    end
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  task automatic do_reset();
    reset_n = 1'b0;
    initPhase23 = 1'b0;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask : do_reset
  // Bounded wait for the next transmit start
  task automatic wait_tx(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (txStart !== 1'b1 && n < 500);
  endtask : wait_tx
  // One status slot; statusValid stands for the single cycle after the slot
  task automatic frame(inout int rdy, inout int dft);
    frameSlot = 1'b1;
    @(negedge clk) frameSlot = 1'b0;
    if (statusValid === 1'b1 && statusFrame === FR_READY) rdy++;
    if (statusValid === 1'b1 && statusFrame === FR_DEFECT) dft++;
    repeat (2) @(negedge clk);
  endtask : frame
  task automatic selftest(input logic [9:0] smp, input logic [3:0] lim, input logic ok,
                          output int rdy, output int dft);
    int n;
    do_reset();
    check(statusFrame, FR_BUSY);
    check(selftestRetryCountTerm, RETRY_RESET);
    sensorSample = smp;
    selftestRetryLimit = lim;
    syncPeriodOk = ok;
    initPhase23 = 1'b1;
    rdy = 0;
    dft = 0;
    n = 0;
    repeat (5) @(negedge clk);
    check(selftestStimulus, 1'b0);
    while (selftestStimulus !== 1'b1 && n < 500) begin
      @(negedge clk);
      n++;
    end
    check(offsetFrozen, 1'b1);
    while (selftestStimulus !== 1'b0 && n < 500) begin
      @(negedge clk);
      n++;
    end
    check(initResult, ok ? {smp, smp} : {RESULT_ZERO, RESULT_ZERO});
    n = 0;
    while (normalMode !== 1'b1 && dft < 2 && n < 300) begin
      frame(rdy, dft);
      n++;
    end
  endtask : selftest

  initial begin
    int rdy, dft, n;
    logic [9:0] a, b;
    do_reset();
    initPhase1 = 1'b1;
    progEntryDecoded = 1'b1;
    repeat (3) @(negedge clk);
    check(programmingMode, 1'b0);
    userLock = 1'b0;
    repeat (3) @(negedge clk);
    check(programmingMode, 1'b1);
    progEntryDecoded = 1'b0;
    initPhase1 = 1'b0;
    $display("programming entry test done");
    // Failing sample value with one retry allowed ends in defect
    selftest(10'h00A, 4'h1, 1'b0, rdy, dft);
    check(dft, 2);
    check(selftestRetryCountTerm, 4'h2);
    check(normalMode, 1'b0);
    $display("self-test failure test done");
    selftest(10'h0C8, 4'h3, 1'b1, rdy, dft);
    check(rdy, 2);
    check(selftestRetryCountTerm, RETRY_RESET);
    check(baseline, 10'h0C8);
    check(normalMode, 1'b1);
    $display("self-test pass test done");
    // Sample changes mid-slot tell the two latch instants apart
    for (int i = 0; i < 4; i++) begin
      modeCfg = '{TX_MODE_NORMAL, 1'b0, i[0], 10'h002};
      syncOn = 1'b1;
      rnd = lfsr(rnd);
      a = {2'h0, rnd};
      b = a ^ 10'h300;
      sensorSample = a;
      @(posedge syncPulse);
      repeat (100) @(negedge clk);
      sensorSample = b;
      wait_tx(n);
      check(txData, i[0] ? b : a);
      check(n >= 100 && n <= 115, 1'b1);
    end
    $display("sampling test done");
    txReady = 1'b0;
    repeat (9) @(posedge syncPulse);
    repeat (250) @(negedge clk);
    check(fifoFull, 1'b1);
    syncOn = 1'b0;
    txReady = 1'b1;
    n = 0;
    repeat (200) begin
      @(negedge clk);
      if (txStart === 1'b1) n++;
    end
    check(n, FIFO_DEPTH);
    $display("buffer test done");
    modeCfg = '{TX_MODE_NORMAL, 1'b1, 1'b0, 10'h002};
    repeat (3) @(negedge clk);
    check(freeRunMode, 1'b0);
    modeCfg.slotAOffset = SLOT_A_ZERO;
    syncOn = 1'b1;
    wait_tx(n);
    check(freeRunMode, 1'b1);
    wait_tx(n);
    check(n, 40);
    $display("free-run test done");
    test_done();
  end
endmodule : testbench
